// File: core/lsac_ctrl.sv
// scan address generator, cursor control and command decoder
`timescale 1ns/1ps

// ----------------------------------------------------------------
// fifo between scan fetch and pixel output
// ----------------------------------------------------------------
module lsac_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = store[rd_ptr];

    // pointers and fill count
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // storage write
    always_ff @(posedge clock) begin
        if (push) store[wr_ptr] <= in_data;
    end
endmodule

// ----------------------------------------------------------------
// top: command port, cursor, raster scanner
// ----------------------------------------------------------------
module lsac_ctrl #(
    parameter int MEM_AW = 15
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    // host indirect port
    input  wire logic         host_wr,
    input  wire logic         host_rd,
    input  wire logic         host_a0,
    input  wire logic [7:0]   host_wdata,
    output logic [7:0]        host_rdata,
    // scan configuration
    input  wire logic         scan_enable,
    input  wire logic         text_mode,
    input  wire logic         dual_panel,
    input  wire logic         tall_glyphs,
    input  wire logic [3:0]   glyph_rows_m1,
    input  wire logic [3:0]   char_width_m1,
    input  wire logic [7:0]   row_byte_count,
    input  wire logic [7:0]   row_total_bytes,
    input  wire logic [7:0]   frame_line_count,
    input  wire logic [15:0]  addr_pitch,
    input  wire logic [15:0]  upper_start,
    input  wire logic [15:0]  lower_start,
    input  wire logic [15:0]  layer1_start,
    input  wire logic [15:0]  layer1_size,
    input  wire logic [15:0]  layer3_start,
    input  wire logic [15:0]  layer3_size,
    // pixel byte stream
    input  wire logic         pix_ready,
    output logic              pix_valid,
    output logic [7:0]        pix_data,
    output logic [3:0]        pix_count,
    output logic              pix_line_last,
    output logic              line_pulse,
    // command registers
    output logic [15:0]       cursor_addr,
    output logic              cursor_visible,
    output logic              cursor_layer_third,
    output logic [3:0]        cursor_shape_width,
    output logic [7:0]        cursor_shape_height,
    output logic [1:0]        cursor_step_dir,
    output logic [7:0]        layer_overlay_cfg,
    output logic [15:0]       glyph_base,
    output logic [2:0]        fine_hscroll,
    output logic [1:0]        pixel_depth
);
    import lsac_pkg::*;

    logic [7:0]  mem [2**MEM_AW];
    logic [7:0]  cmd;
    logic [1:0]  pidx;
    lsac_scan_t  state;
    logic [15:0] line_up;
    logic [15:0] line_lo;
    logic [15:0] scan_addr;
    logic [15:0] gly_addr;
    logic [7:0]  byte_cnt;
    logic [7:0]  pause_cnt;
    logic [7:0]  line_cnt;
    logic [3:0]  glyph_row;
    logic        lower_half;

    // ------------------------------------------------------------
    // host port decode
    // ------------------------------------------------------------
    // select picks command or parameter
    wire cmd_wr   = host_wr && host_a0;
    wire par_wr   = host_wr && !host_a0;
    wire par_rd   = host_rd && host_a0;
    wire is_step  = (host_wdata[7:2] == CMD_STEP_PREFIX);
    wire mem_wr   = par_wr && (cmd == CMD_MEM_WRITE);
    wire mem_rd   = par_rd && (cmd == CMD_MEM_READ);
    wire [MEM_AW-1:0] cur_idx = cursor_addr[MEM_AW-1:0];

    wire [15:0] stepped = (cursor_step_dir == DIR_RIGHT) ? cursor_addr + 16'h0001 :
                          (cursor_step_dir == DIR_LEFT)  ? cursor_addr - 16'h0001 :
                          (cursor_step_dir == DIR_UP)    ? cursor_addr - addr_pitch :
                                                           cursor_addr + addr_pitch;

    // command byte and parameter slot
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cmd  <= RST_BYTE;
            pidx <= 2'h0;
        end else if (cmd_wr) begin
            cmd  <= host_wdata;
            pidx <= 2'h0;
        end else if ((par_wr || par_rd) && pidx != 2'h3) begin
            pidx <= pidx + 2'h1;
        end
    end

    // parameter registers loaded by writes
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cursor_shape_width  <= 4'h0;
            cursor_shape_height <= RST_BYTE;
            cursor_step_dir     <= DIR_RIGHT;
            layer_overlay_cfg   <= RST_BYTE;
            glyph_base          <= RST_WORD;
            fine_hscroll        <= 3'h0;
            pixel_depth         <= DEPTH_1BPP;
        end else if (cmd_wr && is_step) begin
            cursor_step_dir <= host_wdata[1:0];
        end else if (par_wr) begin
            case (cmd)
                CMD_CURSOR_SHAPE: begin
                    if (pidx == 2'h0) cursor_shape_width <= host_wdata[3:0];
                    if (pidx == 2'h1) begin
                        cursor_shape_height <= {host_wdata[SHAPE_SELECT_BIT], 3'h0,
                                                host_wdata[3:0]};
                    end
                end
                CMD_LAYER_BLEND: begin
                    if (pidx == 2'h0) layer_overlay_cfg <= {3'h0, host_wdata[4:0]};
                end
                CMD_GLYPH_BASE: begin
                    if (pidx == 2'h0) glyph_base[7:0]  <= host_wdata;
                    if (pidx == 2'h1) glyph_base[15:8] <= host_wdata;
                end
                CMD_FINE_HSCROLL: begin
                    if (pidx == 2'h0) fine_hscroll <= host_wdata[2:0];
                end
                CMD_PIXEL_DEPTH: begin
                    if (pidx == 2'h0) pixel_depth <= host_wdata[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // cursor address: set by parameters, stepped by memory access
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cursor_addr <= RST_WORD;
        end else if (par_wr && cmd == CMD_CURSOR_SET && pidx == 2'h0) begin
            cursor_addr[7:0] <= host_wdata;
        end else if (par_wr && cmd == CMD_CURSOR_SET && pidx == 2'h1) begin
            cursor_addr[15:8] <= host_wdata;
        end else if (mem_wr || mem_rd) begin
            cursor_addr <= stepped;
        end
    end

    // read answers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            host_rdata <= RST_BYTE;
        end else if (par_rd) begin
            if (cmd == CMD_CURSOR_GET) begin
                host_rdata <= (pidx == 2'h0) ? cursor_addr[7:0] : cursor_addr[15:8];
            end else if (cmd == CMD_MEM_READ) begin
                host_rdata <= mem[cur_idx];
            end else begin
                host_rdata <= RST_BYTE;
            end
        end
    end

    // ------------------------------------------------------------
    // display memory
    // ------------------------------------------------------------
    wire [15:0] rd_addr = (state == SC_CODE) ? scan_addr : gly_addr;
    wire [7:0]  rd_byte = mem[rd_addr[MEM_AW-1:0]];

    always_ff @(posedge clock) begin
        if (mem_wr) mem[cur_idx] <= host_wdata;
    end

    // ------------------------------------------------------------
    // scanner decode
    // ------------------------------------------------------------
    logic        fifo_ready;
    logic        fifo_out_valid;
    logic [12:0] fifo_out_data;
    logic        push;
    logic [3:0]  push_count;
    logic        push_last;

    wire        wide_glyph = (char_width_m1 > 4'h7);
    wire [3:0]  gfx_pixels = (pixel_depth == DEPTH_1BPP) ? PIX_1BPP :
                             (pixel_depth == DEPTH_2BPP) ? PIX_2BPP : PIX_4BPP;
    wire [3:0]  first_pix  = wide_glyph ? PIX_1BPP : char_width_m1 + 4'h1;
    wire [3:0]  second_pix = char_width_m1 - 4'h7;
    // glyph row offset, doubled when wide
    wire [15:0] gly_off    = tall_glyphs ? {4'h0, rd_byte, glyph_row}
                                         : {5'h0, rd_byte, glyph_row[2:0]};
    wire [15:0] gly_start  = glyph_base + (wide_glyph ? {gly_off[14:0], 1'b0} : gly_off);
    wire [7:0]  next_byte  = byte_cnt + 8'h01;
    // row ends at row byte count
    wire        row_done   = (next_byte == row_byte_count);
    wire [7:0]  gap        = row_total_bytes - row_byte_count;
    wire        last_glyph = (glyph_row == glyph_rows_m1);
    wire        advance    = !text_mode || last_glyph;
    wire        frame_done = (line_cnt + 8'h01 >= frame_line_count);
    wire        pause_end  = (pause_cnt <= 8'h01);
    wire        end_pair   = !dual_panel || lower_half;

    // push selection per state
    always_comb begin
        push       = 1'b0;
        push_count = gfx_pixels;
        push_last  = 1'b0;
        case (state)
            SC_CODE: begin
                push      = !text_mode;
                push_last = row_done;
            end
            SC_GLY0: begin
                push       = 1'b1;
                push_count = first_pix;
                push_last  = row_done && !wide_glyph;
            end
            SC_GLY1: begin
                push       = 1'b1;
                push_count = second_pix;
                push_last  = row_done;
            end
            default: begin
            end
        endcase
    end

    wire stall = push && !fifo_ready;
    wire step_byte = !stall && ((state == SC_CODE && !text_mode) ||
                                (state == SC_GLY0 && !wide_glyph) || state == SC_GLY1);

    // ------------------------------------------------------------
    // scanner state machine
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= SC_IDLE;
        end else if (!scan_enable) begin
            state <= SC_IDLE;
        end else begin
            case (state)
                SC_IDLE:  state <= SC_CODE;
                SC_CODE:  if (text_mode) state <= SC_GLY0;
                          else if (step_byte && row_done) state <= SC_PAUSE;
                SC_GLY0:  if (!stall) state <= wide_glyph ? SC_GLY1 :
                                               (row_done ? SC_PAUSE : SC_CODE);
                SC_GLY1:  if (!stall) state <= row_done ? SC_PAUSE : SC_CODE;
                SC_PAUSE: if (pause_end) state <= SC_CODE;
                default:  state <= SC_IDLE;
            endcase
        end
    end

    // line starts advance by pitch every line in graphics mode, once per text line in text mode
    wire [15:0] next_up = frame_done ? upper_start : (advance ? line_up + addr_pitch : line_up);
    wire [15:0] next_lo = frame_done ? lower_start : (advance ? line_lo + addr_pitch : line_lo);
    wire        line_start = (state == SC_IDLE) || (state == SC_PAUSE && pause_end);
    wire [15:0] next_start = (state == SC_IDLE) ? upper_start : (end_pair ? next_up : line_lo);

    // byte walk, glyph address and pause count
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scan_addr <= RST_WORD;
            gly_addr  <= RST_WORD;
            byte_cnt  <= RST_BYTE;
            pause_cnt <= RST_BYTE;
        end else begin
            if (line_start) begin
                scan_addr <= next_start;
                byte_cnt  <= RST_BYTE;
            end else if (step_byte) begin
                scan_addr <= scan_addr + 16'h0001;
                byte_cnt  <= next_byte;
            end
            if (state == SC_CODE && text_mode) begin
                gly_addr <= gly_start;
            end else if (state == SC_GLY0 && !stall) begin
                gly_addr <= gly_addr + 16'h0001;
            end
            if (step_byte && row_done) begin
                pause_cnt <= gap;
            end else if (state == SC_PAUSE) begin
                pause_cnt <= pause_cnt - 8'h01;
            end
        end
    end

    // line bookkeeping at each line end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            line_up    <= RST_WORD;
            line_lo    <= RST_WORD;
            line_cnt   <= RST_BYTE;
            glyph_row  <= 4'h0;
            lower_half <= 1'b0;
            line_pulse <= 1'b0;
        end else if (state == SC_IDLE) begin
            line_up    <= upper_start;
            line_lo    <= lower_start;
            line_cnt   <= RST_BYTE;
            glyph_row  <= 4'h0;
            lower_half <= 1'b0;
            line_pulse <= 1'b0;
        end else if (state == SC_PAUSE && pause_end) begin
            line_pulse <= end_pair;
            lower_half <= dual_panel && !lower_half;
            if (end_pair) begin
                line_up   <= next_up;
                line_lo   <= next_lo;
                line_cnt  <= frame_done ? RST_BYTE : line_cnt + 8'h01;
                glyph_row <= (frame_done || !text_mode || last_glyph) ? 4'h0
                                                                      : glyph_row + 4'h1;
            end
        end else begin
            line_pulse <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // fifo and pixel output stage
    // ------------------------------------------------------------
    wire pix_take = fifo_out_valid && (!pix_valid || pix_ready);

    lsac_fifo #(
        .WIDTH (13),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .nrst      (nrst),
        .in_valid  (push && scan_enable),
        .in_ready  (fifo_ready),
        .in_data   ({push_last, push_count, rd_byte}),
        .out_valid (fifo_out_valid),
        .out_ready (!pix_valid || pix_ready),
        .out_data  (fifo_out_data)
    );

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pix_valid     <= 1'b0;
            pix_data      <= RST_BYTE;
            pix_count     <= 4'h0;
            pix_line_last <= 1'b0;
        end else if (pix_take) begin
            pix_valid     <= 1'b1;
            pix_data      <= fifo_out_data[7:0];
            pix_count     <= fifo_out_data[11:8];
            pix_line_last <= fifo_out_data[12];
        end else if (pix_ready) begin
            pix_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // cursor layer and visibility
    // ------------------------------------------------------------
    // layer from three-layer bit
    wire        third    = layer_overlay_cfg[THREE_LAYER_BIT];
    wire [15:0] lay_base = third ? layer3_start : layer1_start;
    wire [15:0] lay_size = third ? layer3_size : layer1_size;
    wire [15:0] rel      = cursor_addr - lay_base;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cursor_layer_third <= 1'b0;
            cursor_visible     <= 1'b0;
        end else begin
            cursor_layer_third <= third;
            cursor_visible <= (cursor_addr >= lay_base) && (rel < lay_size);
        end
    end

endmodule

// File: core/lsac_pkg.sv
// constants, codes and states shared by the scan/cursor control block
package lsac_pkg;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_CURSOR_SHAPE = 8'h5d;
    localparam logic [5:0] CMD_STEP_PREFIX  = 6'h13;   // codes 4c..4f
    localparam logic [7:0] CMD_LAYER_BLEND  = 8'h5b;
    localparam logic [7:0] CMD_GLYPH_BASE   = 8'h5c;
    localparam logic [7:0] CMD_FINE_HSCROLL = 8'h5a;
    localparam logic [7:0] CMD_CURSOR_SET   = 8'h46;
    localparam logic [7:0] CMD_CURSOR_GET   = 8'h47;
    localparam logic [7:0] CMD_PIXEL_DEPTH  = 8'h60;
    localparam logic [7:0] CMD_MEM_WRITE    = 8'h42;
    localparam logic [7:0] CMD_MEM_READ     = 8'h43;

    // ------------------------------------------------------------
    // register offsets of the indirect map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_ROW_BYTE_COUNT      = 8'h03;
    localparam logic [7:0] REG_ROW_TOTAL_BYTES     = 8'h04;
    localparam logic [7:0] REG_FRAME_LINE_COUNT    = 8'h05;
    localparam logic [7:0] REG_CURSOR_SHAPE_HEIGHT = 8'h16;
    localparam logic [7:0] REG_CURSOR_STEP_DIR     = 8'h17;
    localparam logic [7:0] REG_LAYER_OVERLAY_CFG   = 8'h18;
    localparam logic [7:0] REG_CURSOR_ADDR_LOW     = 8'h1c;
    localparam logic [7:0] REG_CURSOR_ADDR_HIGH    = 8'h1d;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         SHAPE_SELECT_BIT = 7;
    localparam int         THREE_LAYER_BIT  = 4;
    localparam logic [7:0] RST_BYTE         = 8'h00;
    localparam logic [15:0] RST_WORD        = 16'h0000;
    localparam logic [1:0] DIR_RIGHT        = 2'h0;
    localparam logic [1:0] DIR_LEFT         = 2'h1;
    localparam logic [1:0] DIR_UP           = 2'h2;
    localparam logic [1:0] DIR_DOWN         = 2'h3;
    localparam logic [1:0] DEPTH_1BPP       = 2'h0;
    localparam logic [1:0] DEPTH_2BPP       = 2'h1;
    localparam logic [3:0] PIX_1BPP         = 4'h8;
    localparam logic [3:0] PIX_2BPP         = 4'h4;
    localparam logic [3:0] PIX_4BPP         = 4'h2;
    localparam int         FIFO_DEPTH       = 8;

    // scanner states
    typedef enum logic [2:0] {
        SC_IDLE  = 3'b000,
        SC_CODE  = 3'b001,
        SC_GLY0  = 3'b010,
        SC_GLY1  = 3'b011,
        SC_PAUSE = 3'b100
    } lsac_scan_t;

endpackage

// File: tb/lsac_ctrl_asserts.sv
// port assertions for the scan/cursor control block
`timescale 1ns/1ps
module lsac_ctrl_chk import lsac_pkg::*; (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        host_wr,
    input wire logic        host_rd,
    input wire logic        host_a0,
    input wire logic [7:0]  host_wdata,
    input wire logic        pix_valid,
    input wire logic        pix_ready,
    input wire logic [7:0]  pix_data,
    input wire logic        line_pulse,
    input wire logic [15:0] cursor_addr,
    input wire logic [7:0]  cursor_shape_height,
    input wire logic [1:0]  cursor_step_dir,
    input wire logic [7:0]  layer_overlay_cfg,
    input wire logic [15:0] glyph_base,
    input wire logic [2:0]  fine_hscroll,
    input wire logic [1:0]  pixel_depth
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // last command byte and parameter slot
    logic [7:0] cmd;
    logic [1:0] slot;
    wire        pw = host_wr && !host_a0;
    wire        cw = host_wr && host_a0;
    wire        pr = host_rd && host_a0;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cmd <= 8'h00;
            slot <= 2'h0;
        end else if (cw) begin
            cmd <= host_wdata;
            slot <= 2'h0;
        end else if ((pw || pr) && slot != 2'h3) begin
            slot <= slot + 2'h1;
        end
    end
    AST_SHAPE: assert property (pw && cmd == CMD_CURSOR_SHAPE && slot == 2'h1 |=>
        cursor_shape_height == {$past(host_wdata[7]), 3'h0, $past(host_wdata[3:0])})
        else $error("cursor shape height wrong");
    AST_STEP: assert property (cw && host_wdata[7:2] == CMD_STEP_PREFIX |=>
        cursor_step_dir == $past(host_wdata[1:0])) else $error("step direction wrong");
    AST_BLEND: assert property (pw && cmd == CMD_LAYER_BLEND && slot == 2'h0 |=>
        layer_overlay_cfg == {3'h0, $past(host_wdata[4:0])}) else $error("overlay wrong");
    AST_GBASE: assert property (pw && cmd == CMD_GLYPH_BASE && slot == 2'h1 |=>
        glyph_base[15:8] == $past(host_wdata)) else $error("glyph base high wrong");
    AST_HSCR: assert property (pw && cmd == CMD_FINE_HSCROLL && slot == 2'h0 |=>
        fine_hscroll == $past(host_wdata[2:0])) else $error("fine scroll wrong");
    AST_CSET: assert property (pw && cmd == CMD_CURSOR_SET && slot == 2'h0 |=>
        cursor_addr[7:0] == $past(host_wdata)) else $error("cursor low wrong");
    AST_DEPTH: assert property (pw && cmd == CMD_PIXEL_DEPTH && slot == 2'h0 |=>
        pixel_depth == $past(host_wdata[1:0])) else $error("pixel depth wrong");
    AST_HOLD: assert property (pix_valid && !pix_ready |=>
        pix_valid && $stable(pix_data)) else $error("pixel byte dropped");
    AST_PULSE: assert property (line_pulse |=> !line_pulse) else $error("line pulse long");
endmodule
bind lsac_ctrl lsac_ctrl_chk u_chk (.*);

// File: tb/lsac_host.sv
// host processor model on the indirect command port
`timescale 1ns/1ps
module lsac_host (
    input  wire logic       clock,
    input  wire logic [7:0] rdata,
    output logic            wr,
    output logic            rd,
    output logic            a0,
    output logic [7:0]      wd
);
    initial begin
        wr = 0;
        rd = 0;
        a0 = 0;
        wd = 8'h00;
    end
    task automatic put(input logic s, input logic [7:0] d);
        @(negedge clock);
        wr = 1;
        a0 = s;
        wd = d;
        @(negedge clock);
        wr = 0;
        wd = ~d;
    endtask
    // command byte then params in slot order
    task automatic seq(input logic [7:0] c, input logic [7:0] p0, input logic [7:0] p1,
                       input int n);
        put(1'b1, c);
        if (n > 0) put(1'b0, p0);
        if (n > 1) put(1'b0, p1);
    endtask
    // read with select high answers next cycle
    task automatic get(output logic [7:0] q);
        @(negedge clock);
        rd = 1;
        a0 = 1;
        @(negedge clock);
        rd = 0;
        q = rdata;
    endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench for the scan/cursor control block
`timescale 1ns/1ps
module tb_top;
    import lsac_pkg::*;
    logic clock, nrst = 0, en = 0, tm = 0, dual = 0, rdy = 1;
    logic [7:0] rbc = 8'h04, rtb = 8'h06;
    logic [3:0] cwm = 4'h7;
    logic [15:0] pit = 16'h0010, ust = 16'h0000, lst = 16'h0100, l1s = 16'h0000;
    logic [15:0] l1z = 16'h0800, l3s = 16'h1000, l3z = 16'h1000;
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    wire logic wr, rd, a0, pv, pll, lp, cv, c3;
    wire logic [7:0] wd, rdata, pd, sh, oc;
    wire logic [15:0] ca, gb;
    wire logic [3:0] pc, sw;
    wire logic [1:0] sd, dp;
    wire logic [2:0] fh;
    logic [15:0] ex [4] = '{16'h2002, 16'h1ffe, 16'h1fe0, 16'h2020};
    lsac_host h (.clock(clock), .rdata(rdata), .wr(wr), .rd(rd), .a0(a0), .wd(wd));
    lsac_ctrl #(.MEM_AW(8)) dut (.clock(clock), .nrst(nrst), .host_wr(wr), .host_rd(rd),
        .host_a0(a0), .host_wdata(wd), .host_rdata(rdata), .scan_enable(en), .text_mode(tm),
        .dual_panel(dual), .tall_glyphs(1'b0), .glyph_rows_m1(4'h7), .char_width_m1(cwm),
        .row_byte_count(rbc), .row_total_bytes(rtb), .frame_line_count(8'h04),
        .addr_pitch(pit), .upper_start(ust), .lower_start(lst), .layer1_start(l1s),
        .layer1_size(l1z), .layer3_start(l3s), .layer3_size(l3z), .pix_ready(rdy),
        .pix_valid(pv), .pix_data(pd), .pix_count(pc), .pix_line_last(pll), .line_pulse(lp),
        .cursor_addr(ca), .cursor_visible(cv), .cursor_layer_third(c3),
        .cursor_shape_width(sw), .cursor_shape_height(sh), .cursor_step_dir(sd),
        .layer_overlay_cfg(oc), .glyph_base(gb), .fine_hscroll(fh), .pixel_depth(dp));
    initial begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // command decode and cursor readback
    task automatic t_cmds();
        logic [7:0] lo, hi;
        h.seq(CMD_CURSOR_SET, 8'h34, 8'h12, 2);
        h.seq(CMD_CURSOR_GET, 8'h00, 8'h00, 0);
        h.get(lo);
        h.get(hi);
        chk({hi, lo}, 16'h1234);
        h.seq(CMD_CURSOR_SHAPE, 8'h0a, 8'h85, 2);
        chk({sw, sh}, 12'ha85);
        h.seq(CMD_LAYER_BLEND, 8'h1f, 8'h00, 1);
        @(negedge clock);
        chk({c3, cv, oc}, 10'h31f);
        h.seq(CMD_GLYPH_BASE, 8'h78, 8'h56, 2);
        chk(gb, 16'h5678);
        h.seq(CMD_CURSOR_SET, 8'h77, 8'h00, 1);
        h.seq(CMD_FINE_HSCROLL, 8'h05, 8'h00, 1);
        chk({ca, 1'b0, fh}, 20'h12775);
        h.seq(CMD_PIXEL_DEPTH, 8'h02, 8'h00, 1);
        chk(dp, 2'h2);
    endtask
    // auto step on memory writes, every direction
    task automatic t_step();
        logic [7:0] q;
        for (int d = 0; d < 4; d++) begin
            h.seq({CMD_STEP_PREFIX, 2'(d)}, 8'h00, 8'h00, 0);
            h.seq(CMD_CURSOR_SET, 8'h00, 8'h20, 2);
            h.seq(CMD_MEM_WRITE, 8'haa, 8'h55, 2);
            chk({sd, ca}, {2'(d), ex[d]});
        end
        h.seq(CMD_STEP_PREFIX << 2, 8'h00, 8'h00, 0);
        h.seq(CMD_CURSOR_SET, 8'h00, 8'h20, 2);
        h.seq(CMD_MEM_READ, 8'h00, 8'h00, 0);
        h.get(q);
        chk({q, ca}, 24'haa2001);
        // set the cursor to 1234 afterwards
        h.seq(CMD_CURSOR_SET, 8'h34, 8'h12, 2);
    endtask
    task automatic wpl(output logic [7:0] n, output logic [7:0] m);
        int k;
        n = 0;
        m = 0;
        k = 0;
        do begin
            @(negedge clock);
            k++;
            if (pv === 1'b1 && rdy === 1'b1) n++;
            if (pv === 1'b1 && rdy === 1'b1 && pll === 1'b1) m++;
        end while (lp !== 1'b1 && k < 400);
    endtask
    // bytes and line ends between two line pulses
    task automatic t_scan(input logic d, input logic t, input logic [3:0] w, input logic [7:0] e,
                          input logic [3:0] p);
        logic [7:0] n, m;
        @(negedge clock);
        dual = d;
        tm = t;
        cwm = w;
        en = 1;
        wpl(n, m);
        wpl(n, m);
        wpl(n, m);
        chk({n, m, pc}, {e, 8'(d + 1), p});
        en = 0;
        tm = 0;
    endtask
    // sink stalls until the buffer is full
    task automatic t_stall();
        logic [7:0] s;
        @(negedge clock);
        en = 1;
        rdy = 0;
        repeat (30) @(negedge clock);
        s = pd;
        repeat (3) @(negedge clock);
        chk({pv, pd}, {1'b1, s});
        rdy = 1;
        en = 0;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(negedge clock);
        nrst = 1;
        t_cmds();
        t_step();
        t_scan(1'b0, 1'b0, 4'h7, 8'h04, 4'h2);
        t_scan(1'b1, 1'b0, 4'h7, 8'h08, 4'h2);
        t_scan(1'b0, 1'b1, 4'h7, 8'h04, 4'h8);
        // ten-pixel pitch: glyphs held as two bytes per row
        t_scan(1'b0, 1'b1, 4'h9, 8'h08, 4'h2);
        t_stall();
        give_verdict();
    end
endmodule
